// file: common/pdr_regs.svh
`ifndef PDR_REGS_SVH
`define PDR_REGS_SVH
// Register word indices and byte addresses
`define PDR_IDX_RATIOS 8'h19
`define PDR_IDX_PWRDN 8'h1a
`define PDR_IDX_REFFUSE 8'h1b
`define PDR_ADDR_RATIOS 12'h064
`define PDR_ADDR_PWRDN 12'h068
`define PDR_ADDR_REFFUSE 12'h06c
// Reset values
`define PDR_RST_RATIOS 16'h0440
`define PDR_RST_PWRDN 16'h0020
`define PDR_RST_REFFUSE 16'h0000
`define PDR_RST_M_RATIO 8'h04
`define PDR_RST_N_RATIO 5'h05
// Field positions, loop divider ratios
`define PDR_M_HI 15
`define PDR_M_LO 8
`define PDR_M_DOUBLE 15
`define PDR_N_HI 7
`define PDR_N_LO 4
`define PDR_VTRIM_HI 3
`define PDR_VTRIM_LO 2
// Field positions, power-down controls
`define PDR_BAND_HI 15
`define PDR_BAND_LO 10
`define PDR_BIAS_BIT 7
`define PDR_TSENSE_BIT 6
`define PDR_LOOP_BIT 5
`define PDR_CLKRX_BIT 4
`define PDR_CHA_BIT 3
`define PDR_CHB_BIT 2
`define PDR_CHC_BIT 1
`define PDR_CHD_BIT 0
// Field positions, reference and fuse control
`define PDR_EXTREF_BIT 15
`define PDR_FUSE_BIT 11
`endif

// file: common/pdr_pkg.sv
`default_nettype none
package pdr_pkg;
	typedef logic [15:0] pdr_word_t;
	typedef logic [7:0] pdr_mratio_t;
	typedef logic [4:0] pdr_nratio_t;
	typedef enum logic [1:0]
	{
		PDR_SEL_NONE = 2'b00,
		PDR_SEL_RATIOS = 2'b01,
		PDR_SEL_PWRDN = 2'b10,
		PDR_SEL_REFFUSE = 2'b11
	} pdr_sel_e;
endpackage : pdr_pkg
`default_nettype wire

// file: logic/pdr_regs_top.sv
`include "pdr_regs.svh"
`default_nettype none
// Function
// - Top multiplier bit clear: M ratio equals low seven bits, legal 4 to 127.
// - Top multiplier bit set: M ratio is twice low seven bits, 8 to 254.
// - Four-bit reference divider code in bits 7:4 gives N equal code plus one.
// - Multiplier register resets to 0x0440.
// - Power-down bits 15:10 hold six-bit coarse oscillator band, reset zero.
// - Bit 7 set holds bias amplifier asleep.
// - Bit 6 set switches temperature monitor off.
// - Bit 5 set keeps clock loop asleep; resets to one.
// - Bit 4 set powers down clock receiver and sync strobe receiver.
// - Bits 3 to 0 put channels A, B, C, D asleep independently.
// - Power-down register resets to 0x0020.
// - Reference bit 15 selects internal (0) or outside (1) reference.
// - Reference bit 11 set powers down fuse bank; resets zero.
module pdr_regs_top
(
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Loop divider controls
	output pdr_pkg::pdr_mratio_t loop_m_ratio,
	output logic loop_m_invalid,
	output pdr_pkg::pdr_nratio_t loop_n_ratio,
	output logic [1:0] osc_bias_trim,
	output logic [5:0] osc_coarse_band,
	// Power-down controls
	output logic bias_amp_powerdown,
	output logic temp_monitor_powerdown,
	output logic clock_loop_powerdown,
	output logic clock_receiver_powerdown,
	output logic sync_strobe_receiver_powerdown,
	output logic channel_a_powerdown,
	output logic channel_b_powerdown,
	output logic channel_c_powerdown,
	output logic channel_d_powerdown,
	// Reference and fuse controls
	output logic external_reference_select,
	output logic fuse_bank_powerdown
);
	import pdr_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Merge write data into a word under the two low byte strobes
	function automatic pdr_word_t merge_bytes(input pdr_word_t old_w, input logic [15:0] wd, input logic [1:0] be);
		pdr_word_t r;
		r = old_w;
		if (be[0])
		begin
			r[7:0] = wd[7:0];
		end
		if (be[1])
		begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction : merge_bytes

	// M ratio from the multiplier field
	function automatic pdr_mratio_t m_ratio(input logic [7:0] f);
		pdr_mratio_t r;
		if (f[7])
		begin
			r = {f[6:0], 1'b0};
		end
		else
		begin
			r = {1'b0, f[6:0]};
		end
		return r;
	endfunction : m_ratio

	// Codes below 4 in the low seven bits give no legal M in either mode
	function automatic logic m_code_invalid(input logic [7:0] f);
		logic r;
		r = (f[6:0] < 7'h04);
		return r;
	endfunction : m_code_invalid

	// N ratio is the four-bit code plus one
	function automatic pdr_nratio_t n_ratio(input logic [3:0] c);
		pdr_nratio_t r;
		r = {1'b0, c} + 5'h01;
		return r;
	endfunction : n_ratio

	// Read view of the selected register, zero when nothing is selected
	function automatic pdr_word_t read_word(input pdr_sel_e s, input pdr_word_t rat_w, input pdr_word_t pwd_w,
		input pdr_word_t ref_w);
		pdr_word_t r;
		if (s == PDR_SEL_RATIOS)
		begin
			r = rat_w;
		end
		else if (s == PDR_SEL_PWRDN)
		begin
			r = pwd_w;
		end
		else if (s == PDR_SEL_REFFUSE)
		begin
			r = ref_w;
		end
		else
		begin
			r = 16'h0000;
		end
		return r;
	endfunction : read_word

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	pdr_word_t ratios_reg;
	pdr_word_t ratios_next;
	pdr_word_t pwrdn_reg;
	pdr_word_t pwrdn_next;
	pdr_word_t reffuse_reg;
	pdr_word_t reffuse_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pslverr_reg;
	logic pslverr_next;
	pdr_sel_e sel;
	logic access;
	logic setup;
	// Decoded loop divider values, registered
	pdr_mratio_t m_ratio_reg;
	pdr_mratio_t m_ratio_next;
	logic m_invalid_reg;
	logic m_invalid_next;
	pdr_nratio_t n_ratio_reg;
	pdr_nratio_t n_ratio_next;

	// ----------------------------------------
	// Address decode and next state
	// ----------------------------------------
	always_comb
	begin
		if (paddr == `PDR_ADDR_RATIOS)
		begin
			sel = PDR_SEL_RATIOS;
		end
		else if (paddr == `PDR_ADDR_PWRDN)
		begin
			sel = PDR_SEL_PWRDN;
		end
		else if (paddr == `PDR_ADDR_REFFUSE)
		begin
			sel = PDR_SEL_REFFUSE;
		end
		else
		begin
			sel = PDR_SEL_NONE;
		end
	end

	// ----------------------------------------
	// Register writes and read capture
	// ----------------------------------------
	// Writes land at the access edge; a low clock enable refuses them
	assign access = psel & penable & clk_en;
	assign setup = psel & ~penable;

	always_comb
	begin
		ratios_next = ratios_reg;
		pwrdn_next = pwrdn_reg;
		reffuse_next = reffuse_reg;
		prdata_next = 32'h0000_0000;
		pslverr_next = 1'b0;
		// Read data and the error flag are taken at the setup edge, so they leave flip-flops in the access phase
		if (setup)
		begin
			pslverr_next = (sel == PDR_SEL_NONE);
			if (!pwrite)
			begin
				prdata_next = {16'h0000, read_word(sel, ratios_reg, pwrdn_reg, reffuse_reg)};
			end
		end
		// Only a mapped write changes a register
		if (access && pwrite)
		begin
			case (sel)
				PDR_SEL_RATIOS:
				begin
					ratios_next = merge_bytes(ratios_reg, pwdata[15:0], pstrb[1:0]);
				end
				PDR_SEL_PWRDN:
				begin
					pwrdn_next = merge_bytes(pwrdn_reg, pwdata[15:0], pstrb[1:0]);
				end
				PDR_SEL_REFFUSE:
				begin
					reffuse_next = merge_bytes(reffuse_reg, pwdata[15:0], pstrb[1:0]);
				end
				default:
				begin
					// Unmapped: nothing is stored
					ratios_next = ratios_reg;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ratios_reg <= `PDR_RST_RATIOS;
			pwrdn_reg <= `PDR_RST_PWRDN;
			reffuse_reg <= `PDR_RST_REFFUSE;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			ratios_reg <= ratios_next;
			pwrdn_reg <= pwrdn_next;
			reffuse_reg <= reffuse_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// ----------------------------------------
	// Loop divider decode, registered beside its source
	// ----------------------------------------
	// Decoded from the next register value so both move at the same edge
	// Invalid M codes are only flagged; the divider value is passed on unchanged
	always_comb
	begin
		m_ratio_next = m_ratio(ratios_next[`PDR_M_HI:`PDR_M_LO]);
		m_invalid_next = m_code_invalid(ratios_next[`PDR_M_HI:`PDR_M_LO]);
		n_ratio_next = n_ratio(ratios_next[`PDR_N_HI:`PDR_N_LO]);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			m_ratio_reg <= `PDR_RST_M_RATIO;
			m_invalid_reg <= 1'b0;
			n_ratio_reg <= `PDR_RST_N_RATIO;
		end
		else if (clk_en)
		begin
			m_ratio_reg <= m_ratio_next;
			m_invalid_reg <= m_invalid_next;
			n_ratio_reg <= n_ratio_next;
		end
	end

	// ----------------------------------------
	// APB answer
	// ----------------------------------------
	// Zero-wait: the access phase completes at its first edge
	assign pready = 1'b1;
	assign prdata = prdata_reg;
	// The error flag is gated so that it stands only in the access phase
	assign pslverr = psel & penable & pslverr_reg;

	// ----------------------------------------
	// Control outputs
	// ----------------------------------------
	// Divider values come from their own flip-flops, the rest straight from register bits
	assign loop_m_ratio = m_ratio_reg;
	assign loop_m_invalid = m_invalid_reg;
	assign loop_n_ratio = n_ratio_reg;
	assign osc_bias_trim = ratios_reg[`PDR_VTRIM_HI:`PDR_VTRIM_LO];
	assign osc_coarse_band = pwrdn_reg[`PDR_BAND_HI:`PDR_BAND_LO];
	assign bias_amp_powerdown = pwrdn_reg[`PDR_BIAS_BIT];
	assign temp_monitor_powerdown = pwrdn_reg[`PDR_TSENSE_BIT];
	assign clock_loop_powerdown = pwrdn_reg[`PDR_LOOP_BIT];
	assign clock_receiver_powerdown = pwrdn_reg[`PDR_CLKRX_BIT];
	assign sync_strobe_receiver_powerdown = pwrdn_reg[`PDR_CLKRX_BIT];
	assign channel_a_powerdown = pwrdn_reg[`PDR_CHA_BIT];
	assign channel_b_powerdown = pwrdn_reg[`PDR_CHB_BIT];
	assign channel_c_powerdown = pwrdn_reg[`PDR_CHC_BIT];
	assign channel_d_powerdown = pwrdn_reg[`PDR_CHD_BIT];
	assign external_reference_select = reffuse_reg[`PDR_EXTREF_BIT];
	assign fuse_bank_powerdown = reffuse_reg[`PDR_FUSE_BIT];

	logic unused_ok;
	assign unused_ok = &{1'b0, pwdata[31:16], pstrb[3:2]};
endmodule : pdr_regs_top
`default_nettype wire

// file: test/pdr_regs_props.sv
`include "pdr_regs.svh"
`default_nettype none
module pdr_regs_props
(
	// APB side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	// Controls
	input wire pdr_pkg::pdr_mratio_t loop_m_ratio,
	input wire logic loop_m_invalid,
	input wire pdr_pkg::pdr_nratio_t loop_n_ratio,
	input wire logic clock_loop_powerdown,
	input wire logic clock_receiver_powerdown,
	input wire logic sync_strobe_receiver_powerdown,
	input wire logic channel_a_powerdown,
	input wire logic external_reference_select,
	input wire logic fuse_bank_powerdown
);
	timeunit 1ns;
	timeprecision 1ps;
	logic acc;
	assign acc = psel && penable && pwrite && clk_en && pstrb[1:0] == 2'b11;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_M_RATIO: assert property (acc && paddr == `PDR_ADDR_RATIOS |=> loop_m_ratio == ($past(pwdata[15]) ?
		{$past(pwdata[14:8]), 1'b0} : {1'b0, $past(pwdata[14:8])})) else $error("m ratio wrong");
	AST_M_BAD: assert property (acc && paddr == `PDR_ADDR_RATIOS |=> loop_m_invalid == ($past(pwdata[14:8]) < 7'd4))
		else $error("m invalid flag wrong");
	AST_N_RATIO: assert property (acc && paddr == `PDR_ADDR_RATIOS |=> loop_n_ratio == $past(pwdata[7:4]) + 5'd1)
		else $error("n ratio wrong");
	AST_RST: assert property ($rose(presetn) |-> clock_loop_powerdown && loop_n_ratio == 5'd5 && loop_m_ratio == 8'd4)
		else $error("reset values wrong");
	AST_STROBE_RX: assert property (sync_strobe_receiver_powerdown == clock_receiver_powerdown)
		else $error("receivers differ");
	AST_CHAN_A: assert property (acc && paddr == `PDR_ADDR_PWRDN |=> channel_a_powerdown == $past(pwdata[3]))
		else $error("channel a wrong");
	AST_LOOP_WR: assert property (acc && paddr == `PDR_ADDR_PWRDN |=> clock_loop_powerdown == $past(pwdata[5]))
		else $error("loop sleep wrong");
	AST_REF: assert property (acc && paddr == `PDR_ADDR_REFFUSE |=> {external_reference_select,
		fuse_bank_powerdown} == {$past(pwdata[15]), $past(pwdata[11])}) else $error("ref or fuse wrong");
	C_PD: cover property (acc && paddr == `PDR_ADDR_PWRDN);
	C_M_MAX: cover property (loop_m_ratio == 8'd254);
	C_REF: cover property (external_reference_select && fuse_bank_powerdown);
endmodule : pdr_regs_props
bind pdr_regs_top pdr_regs_props u_pdr_regs_props (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .loop_m_ratio, .loop_m_invalid, .loop_n_ratio, .clock_loop_powerdown, .clock_receiver_powerdown,
	.sync_strobe_receiver_powerdown, .channel_a_powerdown, .external_reference_select, .fuse_bank_powerdown);
`default_nettype wire

// file: test/tb.sv
`include "pdr_regs.svh"
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pdr_pkg::*;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err, loop_m_invalid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [7:0] f;
	pdr_mratio_t loop_m_ratio;
	pdr_nratio_t loop_n_ratio;
	logic [1:0] osc_bias_trim;
	logic [5:0] osc_coarse_band;
	logic bias_amp_powerdown, temp_monitor_powerdown, clock_loop_powerdown, clock_receiver_powerdown;
	logic sync_strobe_receiver_powerdown, channel_a_powerdown, channel_b_powerdown, channel_c_powerdown;
	logic channel_d_powerdown, external_reference_select, fuse_bank_powerdown;
	logic [7:0] mt [6] = '{8'h04, 8'h7f, 8'h84, 8'hff, 8'h05, 8'hc0};
	int miscompares, n_checks;
	wire logic [7:0] pd = {bias_amp_powerdown, temp_monitor_powerdown, clock_loop_powerdown, clock_receiver_powerdown,
		channel_a_powerdown, channel_b_powerdown, channel_c_powerdown, channel_d_powerdown};
	pdr_regs_top u_pdr_regs_top (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .loop_m_ratio, .loop_m_invalid, .loop_n_ratio, .osc_bias_trim, .osc_coarse_band,
		.bias_amp_powerdown, .temp_monitor_powerdown, .clock_loop_powerdown, .clock_receiver_powerdown,
		.sync_strobe_receiver_powerdown, .channel_a_powerdown, .channel_b_powerdown, .channel_c_powerdown,
		.channel_d_powerdown, .external_reference_select, .fuse_bank_powerdown);
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial
	begin
		#400000;
		miscompares++;
		close_out();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		clk_en = 1'b1;
		pstrb = 4'hf;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, `PDR_ADDR_RATIOS, 0); `CHK(rd, 32'h0000_0440)
		xfer(1'b0, `PDR_ADDR_PWRDN, 0); `CHK(rd, 32'h0000_0020)
		xfer(1'b0, `PDR_ADDR_REFFUSE, 0); `CHK(rd, 32'h0000_0000)
		$display("reset test done");
		for (int i = 0; i < 16; i++)
		begin
			f = mt[i % 6];
			xfer(1'b1, `PDR_ADDR_RATIOS, {16'h0000, f, i[3:0], 4'b0100});
			`CHK(loop_m_ratio, f[7] ? {f[6:0], 1'b0} : {1'b0, f[6:0]})
			`CHK(loop_m_invalid, f[6:0] < 7'd4)
			`CHK(loop_n_ratio, {1'b0, i[3:0]} + 5'd1)
			`CHK(osc_bias_trim, 2'b01)
			xfer(1'b0, `PDR_ADDR_RATIOS, 0); `CHK(rd[15:0], {f, i[3:0], 4'b0100})
		end
		$display("ratio test done");
		for (int b = 0; b < 8; b++)
		begin
			xfer(1'b1, `PDR_ADDR_PWRDN, {16'h0000, 6'h2a ^ b[5:0], 2'b00, 8'h01 << b});
			`CHK(pd, 8'h01 << b)
			`CHK(osc_coarse_band, 6'h2a ^ b[5:0])
			`CHK(sync_strobe_receiver_powerdown, b == 4)
		end
		pstrb <= 4'h1;
		xfer(1'b1, `PDR_ADDR_PWRDN, 32'h0000_fc0f);
		pstrb <= 4'hf;
		`CHK(pd, 8'h0f)
		clk_en <= 1'b0;
		xfer(1'b1, `PDR_ADDR_PWRDN, 0);
		clk_en <= 1'b1;
		xfer(1'b1, 12'h070, 32'h0000_ffff); `CHK(err, 1'b1)
		xfer(1'b0, `PDR_ADDR_PWRDN, 0); `CHK(rd[15:0], 16'hb40f)
		$display("power-down test done");
		xfer(1'b1, 12'h08c, 0); `CHK(err, 1'b1)
		xfer(1'b1, `PDR_ADDR_REFFUSE, 32'h0000_8800); `CHK({external_reference_select, fuse_bank_powerdown}, 2'b11)
		xfer(1'b1, `PDR_ADDR_REFFUSE, 32'h0000_0800); `CHK({external_reference_select, fuse_bank_powerdown}, 2'b01)
		$display("reference test done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, `PDR_ADDR_REFFUSE, 0); `CHK(rd, 32'h0000_0000)
		`CHK({loop_m_ratio, loop_n_ratio, pd}, {8'h04, 5'h05, 8'h20})
		$display("second reset test done");
		close_out();
	end
endmodule : tb
`default_nettype wire
